// File: rtl/i2crs_brg.sv
// Purpose: down-counting bit-rate counter
// Assumes: reload value N gives an expiry N+1 cycles after load
// Notes:   halt wins over a running count, load wins over halt
`timescale 1ns/10ps
`default_nettype none
module i2crs_brg
    import i2crs_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst,
    i2crs_brg_if.cnt    brg
);

    i2crs_byte_t cnt_q;
    logic        run_q;
    wire         at_zero;

    // expiry is combinational so the sequencer reacts the same cycle
    assign at_zero     = (cnt_q == 8'h00);
    assign brg.expired = run_q & at_zero;
    assign brg.running = run_q;

    // counter core
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            run_q <= 1'b0;
        end else if (brg.load) begin
            cnt_q <= brg.reload;
            run_q <= 1'b1;
        end else if (brg.halt || at_zero) begin
            run_q <= 1'b0;
        end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

endmodule : i2crs_brg
`default_nettype wire

// File: rtl/i2crs_top.sv
// Purpose: repeated start generation with bus collision detection
// Assumes: open-drain pins, oe high while the line is pulled low
// Notes:   pins pass three flops; a change counts when 2nd and 3rd agree
//          lines stay pulled low after a finished repeated start
`timescale 1ns/10ps
`default_nettype none
`include "i2crs_defines.svh"
module i2crs_top
    import i2crs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    i2crs_state_t state_q;
    i2crs_state_t state_d;
    i2crs_byte_t  reload_q;
    i2crs_byte_t  flag_q;
    i2crs_byte_t  flag_d;
    i2crs_byte_t  ien_q;
    i2crs_byte_t  rdata_q;
    logic         scl_drv_q;
    logic         scl_drv_d;
    logic         sda_drv_q;
    logic         sda_drv_d;
    logic         scl_lvl_q;
    logic         sda_lvl_q;
    logic         scl_prev_q;
    logic [`I2CRS_SYNC_LEN-1:0] sync_q [2];
    wire  [1:0]   pin_raw;
    wire          scl_rise;
    wire          scl_fall;
    wire          start_req;
    wire          coll_case1;
    wire          coll_case2;
    wire          coll_any;
    wire          done_ev;
    wire          busy;
    wire          wr_flag;
    wire          wr_ien;
    wire          wr_reload;
    wire          wr_ctrl;
    wire [7:0]    rd_mux;
    wire [7:0]    stat_val;
    // decoded state and counter reload terms
    wire          st_idle;
    wire          st_wait_sda;
    wire          st_wait_scl;
    wire          st_cnt_high;
    wire          st_cnt_hold;
    wire          load_float;
    wire          load_high;
    wire          load_hold;

    i2crs_brg_if brg ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // register select, shared by write and read decode
    function automatic logic reg_sel(input logic [2:0] a,
                                     input logic [2:0] ofs);
        reg_sel = (a == ofs);
    endfunction : reg_sel

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    assign pin_raw = {sda_in, scl_in};

    // three flops per pin; only stages two and three are looked at
    // reset to ones: an idle bus reads high, so no false edge follows
    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    sync_q[i] <= {`I2CRS_SYNC_LEN{1'b1}};
                end else begin
                    sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
                end
            end
        end
    endgenerate

    // a new level is accepted once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_lvl_q  <= 1'b1;
            sda_lvl_q  <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            if (sync_q[0][1] == sync_q[0][2]) begin
                scl_lvl_q <= sync_q[0][2];
            end
            if (sync_q[1][1] == sync_q[1][2]) begin
                sda_lvl_q <= sync_q[1][2];
            end
            scl_prev_q <= scl_lvl_q;
        end
    end

    // clock edges found on the filtered level
    assign scl_rise = scl_lvl_q & ~scl_prev_q;
    assign scl_fall = ~scl_lvl_q & scl_prev_q;

    // ----------------------------------------------------------------
    // state decode
    // ----------------------------------------------------------------
    // full compares on the one-hot codes tie each step to its enum name
    assign st_idle     = (state_q == I2CRS_IDLE);
    assign st_wait_sda = (state_q == I2CRS_WAIT_SDA);
    assign st_wait_scl = (state_q == I2CRS_WAIT_SCL);
    assign st_cnt_high = (state_q == I2CRS_CNT_HIGH);
    assign st_cnt_hold = (state_q == I2CRS_CNT_HOLD);

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    assign wr_ctrl   = reg_wr & reg_sel(reg_addr, `I2CRS_OFS_CTRL);
    assign wr_reload = reg_wr & reg_sel(reg_addr, `I2CRS_OFS_RELOAD);
    assign wr_flag   = reg_wr & reg_sel(reg_addr, `I2CRS_OFS_FLAG);
    assign wr_ien    = reg_wr & reg_sel(reg_addr, `I2CRS_OFS_IEN);
    // a request while busy is dropped, never queued
    assign busy      = ~st_idle;
    assign start_req = wr_ctrl & reg_wdata[`I2CRS_BIT_RSREQ] & ~busy;
    // status mirrors the one-hot state so software can follow each step
    assign stat_val  = {2'b00, state_q};

    // read mux; unmapped offsets read zero
    assign rd_mux =
        reg_sel(reg_addr, `I2CRS_OFS_CTRL)   ? {7'h00, busy}  :
        reg_sel(reg_addr, `I2CRS_OFS_RELOAD) ? reload_q       :
        reg_sel(reg_addr, `I2CRS_OFS_FLAG)   ? flag_q         :
        reg_sel(reg_addr, `I2CRS_OFS_IEN)    ? ien_q          :
        reg_sel(reg_addr, `I2CRS_OFS_STAT)   ? stat_val       :
                                               8'h00;

    // zero outside the answer cycle keeps a shared read bus quiet
    // read data stand in the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // software-owned registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reload_q <= `I2CRS_RST_RELOAD;
            ien_q    <= `I2CRS_RST_REG;
        end else begin
            if (wr_reload) begin
                reload_q <= reg_wdata;
            end
            if (wr_ien) begin
                ien_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // collision detection
    // ----------------------------------------------------------------
    // limitation: a pin change is seen three to four cycles late, so a
    // clock fall just before an expiry is judged after the step is taken
    // both cases end the same way: flag, release, idle
    // data low when clock is seen high after release
    assign coll_case1 = st_wait_scl & scl_rise & ~sda_lvl_q;
    // clock pulled low by another master before data is driven
    assign coll_case2 = st_cnt_high & scl_fall & ~sda_drv_q;
    assign coll_any   = coll_case1 | coll_case2;
    assign done_ev    = st_cnt_hold & brg.expired;

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    // the done flag lets software poll for the end without the pins
    // write one clears; a same-cycle event keeps its bit set
    always_comb begin
        flag_d = flag_q;
        if (wr_flag) begin
            flag_d = flag_q & ~reg_wdata;
        end
        if (coll_any) begin
            flag_d[`I2CRS_BIT_COLL] = 1'b1;
        end
        if (done_ev) begin
            flag_d[`I2CRS_BIT_DONE] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_q <= `I2CRS_RST_REG;
        end else begin
            flag_q <= flag_d;
        end
    end

    // level interrupt while any unmasked flag is set
    assign irq = |(flag_q & ien_q);

    // ----------------------------------------------------------------
    // bit-rate counter
    // ----------------------------------------------------------------
    // the reload value is read at each load, so a write during a count
    // only takes effect at the next reload point
    assign brg.reload = reload_q;
    // load when data floats high, when clock reads high with data high,
    // and at the end of the high phase, whether or not another master
    // has already pulled data low; a collision in that same cycle blocks
    // the reload, since load would otherwise win over halt
    assign load_float = st_wait_sda & sda_lvl_q;
    assign load_high  = st_wait_scl & scl_rise & sda_lvl_q;
    assign load_hold  = st_cnt_high & brg.expired & ~coll_case2;
    assign brg.load   = load_float | load_high | load_hold;
    assign brg.halt   = coll_any;

    // counter in its own module keeps its expiry timing in one place
    i2crs_brg u_brg (
        .core_clk (core_clk),
        .rst      (rst),
        .brg      (brg)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // next state and line drives; collision wins over every step
    always_comb begin
        state_d   = state_q;
        scl_drv_d = scl_drv_q;
        sda_drv_d = sda_drv_q;
        unique case (state_q)
            I2CRS_IDLE: begin
                if (start_req) begin
                    // hold clock low, let data float up
                    state_d   = I2CRS_WAIT_SDA;
                    scl_drv_d = 1'b1;
                    sda_drv_d = 1'b0;
                end
            end
            I2CRS_WAIT_SDA: begin
                // another master may still hold data low: wait, no flag
                if (sda_lvl_q) begin
                    state_d = I2CRS_CNT_LOW;
                end
            end
            I2CRS_CNT_LOW: begin
                // clock stays pulled low for the whole first count
                if (brg.expired) begin
                    state_d   = I2CRS_WAIT_SCL;
                    scl_drv_d = 1'b0;
                end
            end
            I2CRS_WAIT_SCL: begin
                // a slave stretching the clock just lengthens this wait
                if (scl_rise && sda_lvl_q) begin
                    state_d = I2CRS_CNT_HIGH;
                end
            end
            I2CRS_CNT_HIGH: begin
                // a data fall from another master alone is tolerated
                if (brg.expired && scl_lvl_q && sda_lvl_q) begin
                    state_d   = I2CRS_CNT_HOLD;
                    sda_drv_d = 1'b1;
                end else if (brg.expired) begin
                    // data pulled low by another start: same outcome
                    state_d   = I2CRS_CNT_HOLD;
                    sda_drv_d = 1'b1;
                end
            end
            I2CRS_CNT_HOLD: begin
                if (brg.expired) begin
                    // clock pulled low whatever it reads now
                    state_d   = I2CRS_IDLE;
                    scl_drv_d = 1'b1;
                end
            end
        endcase
        if (coll_any) begin
            state_d   = I2CRS_IDLE;
            scl_drv_d = 1'b0;
            sda_drv_d = 1'b0;
        end
    end

    // lines are held after a finished repeated start; only a new
    // request, which lets data go, or reset releases them, so the next stage of
    // the master finds the bus still in its hands
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= I2CRS_IDLE;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            scl_drv_q <= scl_drv_d;
            sda_drv_q <= sda_drv_d;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // drives come straight from flops, so no next-state glitch reaches a pin
    // open drain: only ever pull low, enable marks the pull
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_drv_q;
    assign sda_oe  = sda_drv_q;

endmodule : i2crs_top
`default_nettype wire

// File: shared/i2crs_brg_if.sv
// Purpose: carrier between sequencer and bit-rate counter
// Assumes: both ends on core_clk
// Notes:   expired is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface i2crs_brg_if;
    logic       load;
    logic       halt;
    logic [7:0] reload;
    logic       expired;
    logic       running;

    modport seq (output load, output halt, output reload,
                 input expired, input running);
    modport cnt (input load, input halt, input reload,
                 output expired, output running);
endinterface : i2crs_brg_if
`default_nettype wire

// File: shared/i2crs_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers on a 3-bit word index
// Notes:   definitions only
`ifndef I2CRS_DEFINES_SVH
`define I2CRS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define I2CRS_OFS_CTRL   3'h0
`define I2CRS_OFS_RELOAD 3'h1
`define I2CRS_OFS_FLAG   3'h2
`define I2CRS_OFS_IEN    3'h3
`define I2CRS_OFS_STAT   3'h4

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define I2CRS_BIT_RSREQ  0
`define I2CRS_BIT_DONE   0
`define I2CRS_BIT_COLL   3
`define I2CRS_RST_RELOAD 8'h09
`define I2CRS_RST_REG    8'h00
`define I2CRS_SYNC_LEN   3

`endif

// File: shared/i2crs_pkg.sv
// Purpose: types shared by the repeated start collision block
// Assumes: one-hot sequencer state
// Notes:   numbers live in the defines header
package i2crs_pkg;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        I2CRS_IDLE     = 6'h01,
        I2CRS_WAIT_SDA = 6'h02,
        I2CRS_CNT_LOW  = 6'h04,
        I2CRS_WAIT_SCL = 6'h08,
        I2CRS_CNT_HIGH = 6'h10,
        I2CRS_CNT_HOLD = 6'h20
    } i2crs_state_t;

    typedef logic [7:0] i2crs_byte_t;

endpackage : i2crs_pkg

// File: sim/i2crs_bus_model.sv
// Purpose: pull-ups and another master on the two-wire bus
// Assumes: wired-and lines, idle high
// Notes:   the foreign clock only runs while scl_run is high
`timescale 1ns/10ps
`default_nettype none
module i2crs_bus_model (
    input  wire logic scl_out,
    input  wire logic scl_oe,
    input  wire logic sda_out,
    input  wire logic sda_oe,
    input  wire logic sda_hold,
    input  wire logic sda_zero,
    input  wire logic scl_run,
    output logic      scl_in,
    output logic      sda_in
);
    logic scl_pull = 1'b0;
    // 160 ns foreign clock, low half first; stands high between bursts
    always begin
        #80;
        scl_pull = scl_run ? ~scl_pull : 1'b0;
    end
    // any party pulling low wins; sda_zero sends a zero as soon as
    // the block lets its clock go, so both lines move together
    assign scl_in = (scl_oe ? scl_out : 1'b1) & ~scl_pull;
    assign sda_in = (sda_oe ? sda_out : 1'b1) & ~sda_hold
                    & ~(sda_zero & ~scl_oe);
endmodule : i2crs_bus_model
`default_nettype wire

// File: sim/i2crs_top_asserts.sv
// Purpose: port checks for the repeated start block
// Assumes: one clock; reload value shadowed from register writes
// Notes:   bound to i2crs_top
`timescale 1ns/10ps
`default_nettype none
module i2crs_top_asserts (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq,
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe
);
    logic [7:0] reload_q;
    logic [7:0] low_q;
    logic [7:0] hold_q;
    // phase lengths are judged against a shadow of the reload value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reload_q <= 8'h09;
            low_q    <= 8'h00;
            hold_q   <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == 3'h1) reload_q <= reg_wdata;
            low_q  <= (scl_oe && !sda_oe) ? low_q + 8'h01 : 8'h00;
            hold_q <= (sda_oe && !scl_oe) ? hold_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_drive; $rose(sda_oe); endsequence
    sequence s_done; $rose(scl_oe) ##0 sda_oe; endsequence
    a_rdata_quiet:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_reset_quiet:
        assert property ($past(rst) |-> !irq && !scl_oe && !sda_oe)
        else $error("outputs active after reset");
    a_release_len:
        assert property ($fell(scl_oe) && !sda_oe |-> low_q >= reload_q)
        else $error("clock released early");
    a_sda_order:
        assert property (s_drive |-> !scl_oe && !$past(scl_oe))
        else $error("data pulled while clock pulled");
    a_done_order:
        assert property (s_done |-> $past(sda_oe, 2))
        else $error("clock pulled too soon after data");
    a_hold_len:
        assert property (s_done |-> hold_q >= reload_q &&
                         hold_q <= reload_q + 8'h02)
        else $error("final count length wrong");
    a_done_holds:
        assert property (s_done |=> (scl_oe && sda_oe) [*3])
        else $error("lines not held after finish");
    a_coll_quiet:
        assert property ($fell(scl_in) && !scl_oe && !sda_oe
                         |-> !sda_oe [*8])
        else $error("data driven after clock collision");
    a_irq_mask:
        assert property (reg_wr && reg_addr == 3'h3 &&
                         reg_wdata == 8'h00 |=> !irq)
        else $error("irq high while fully masked");
endmodule : i2crs_top_asserts
bind i2crs_top i2crs_top_asserts i2crs_top_asserts_inst (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .scl_in, .scl_out, .scl_oe, .sda_in,
    .sda_out, .sda_oe
);
`default_nettype wire

// File: sim/i2crs_top_tb.sv
// Purpose: self-checking bench for the repeated start block
// Assumes: bus model gives pull-ups and the competing master
// Notes:   small reload values keep every phase short
`timescale 1ns/10ps
`default_nettype none
module i2crs_top_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       irq, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
    logic       sda_hold = 1'b0;
    logic       sda_zero = 1'b0;
    logic       scl_run = 1'b0;
    int         err_count = 0;
    int         cmp_count = 0;
    i2crs_top i2crs_top_inst (
        .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .scl_in, .scl_out, .scl_oe, .sda_in,
        .sda_out, .sda_oe
    );
    i2crs_bus_model i2crs_bus_model_inst (
        .scl_out, .scl_oe, .sda_out, .sda_oe, .sda_hold, .sda_zero,
        .scl_run, .scl_in, .sda_in
    );
    always #5 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e,
                      input string n);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask : rd
    // bounded wait for scl_oe (0), sda_oe (1) or irq (2) to reach v
    task automatic wait_on(input int sel, input logic v);
        int   k;
        logic s;
        k = 0;
        s = ~v;
        while (s !== v && k < 600) begin
            @(posedge core_clk);
            #1;
            k++;
            s = sel == 0 ? scl_oe : sel == 1 ? sda_oe : irq;
        end
        chk("wait", {7'h00, v}, {7'h00, s});
    endtask : wait_on
    task automatic t_regs;
        rd(3'h1, 8'h09, "reload");
        rd(3'h3, 8'h00, "irq_en");
        rd(3'h2, 8'h00, "flags");
        rd(3'h4, 8'h01, "state");
        rd(3'h7, 8'h00, "unmapped");
        wr(3'h1, 8'h04);
        rd(3'h1, 8'h04, "reload_rw");
    endtask : t_regs
    // clean run; a second request while busy is ignored
    task automatic t_plain;
        wr(3'h3, 8'h01);
        wr(3'h0, 8'h01);
        rd(3'h0, 8'h01, "busy");
        wr(3'h0, 8'h01);
        wait_on(0, 1'b0);
        wait_on(1, 1'b1);
        chk("scl_rel", 8'h00, {7'h00, scl_oe});
        wait_on(0, 1'b1);
        chk("sda_held", 8'h01, {7'h00, sda_oe});
        rd(3'h2, 8'h01, "flags_done");
        rd(3'h0, 8'h00, "idle");
        chk("irq_on", 8'h01, {7'h00, irq});
        wr(3'h3, 8'h00);
        chk("irq_masked", 8'h00, {7'h00, irq});
        wr(3'h3, 8'h01);
        wr(3'h2, 8'h01);
        chk("irq_clear", 8'h00, {7'h00, irq});
    endtask : t_plain
    // another master sends a zero as the clock is let go
    task automatic t_case1;
        wr(3'h3, 8'h08);
        wr(3'h0, 8'h01);
        @(posedge core_clk) sda_zero <= 1'b1;
        wait_on(2, 1'b1);
        chk("lines", 8'h00, {6'h00, scl_oe, sda_oe});
        rd(3'h2, 8'h08, "flags_c1");
        rd(3'h4, 8'h01, "state_c1");
        @(posedge core_clk) sda_zero <= 1'b0;
        wr(3'h2, 8'h08);
    endtask : t_case1
    // another master clocks the line low in the high phase
    task automatic t_case2;
        wr(3'h1, 8'h28);
        wr(3'h0, 8'h01);
        wait_on(0, 1'b0);
        repeat (8) @(posedge core_clk);
        scl_run <= 1'b1;
        wait_on(2, 1'b1);
        chk("sda_free", 8'h00, {7'h00, sda_oe});
        rd(3'h2, 8'h08, "flags_c2");
        @(posedge core_clk) scl_run <= 1'b0;
        wr(3'h2, 8'h08);
    endtask : t_case2
    // data pulled low by another master before the count expires
    task automatic t_early_sda;
        wr(3'h3, 8'h09);
        wr(3'h0, 8'h01);
        wait_on(0, 1'b0);
        repeat (10) @(posedge core_clk);
        sda_hold <= 1'b1;
        wait_on(0, 1'b1);
        rd(3'h2, 8'h01, "flags_ok");
        @(posedge core_clk) sda_hold <= 1'b0;
        wr(3'h2, 8'h09);
        chk("irq_end", 8'h00, {7'h00, irq});
    endtask : t_early_sda
    // reset in mid-run drops the lines and restores every register
    task automatic t_reset;
        wr(3'h1, 8'h05);
        wr(3'h0, 8'h01);
        repeat (3) @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk("lines_rst", 8'h00, {4'h0, scl_oe, sda_oe, scl_out, sda_out});
        chk("irq_rst", 8'h00, {7'h00, irq});
        rd(3'h1, 8'h09, "reload_rst");
        rd(3'h2, 8'h00, "flags_rst");
        rd(3'h3, 8'h00, "irq_en_rst");
        rd(3'h4, 8'h01, "state_rst");
    endtask : t_reset
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_plain();
        t_case1();
        t_case2();
        t_early_sda();
        t_reset();
        finish_test();
    end
    // the whole run takes a few hundred cycles
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule : i2crs_top_tb
`default_nettype wire
